// file: rtl/lockout_pkg.sv
// Constants and types shared by the input supply lockout monitor.
`default_nettype none
package lockout_pkg;

  // ****************************************************************
  // Register map, byte addresses on the register bus.
  // ****************************************************************
  localparam int ADR_W = 4;
  localparam logic [ADR_W-1:0] CTRL_OFS = 4'h0;
  localparam logic [ADR_W-1:0] LOW_THR_OFS = 4'h4;
  localparam logic [ADR_W-1:0] HIGH_THR_OFS = 4'h8;
  localparam logic [ADR_W-1:0] FLAG_OFS = 4'hc;

  // ****************************************************************
  // Field layout and reset values.
  // ****************************************************************
  localparam int CODE_W = 4;
  localparam int REG_W = 8;
  localparam int LEVEL_W = 16;
  localparam int NUM_CH = 2;
  localparam int LOW_CH = 0;
  localparam int HIGH_CH = 1;
  localparam logic [REG_W-1:0] CTRL_RST = 8'h00;
  localparam logic [CODE_W-1:0] CODE_RST = 4'h0;
  localparam logic [REG_W-1:0] CTRL_WR_MASK = 8'hbb;

  // ****************************************************************
  // Threshold scale in millivolts.
  // ****************************************************************
  localparam logic [LEVEL_W-1:0] LOW_BASE_MV = 16'h0fa0;
  localparam logic [LEVEL_W-1:0] HIGH_BASE_MV = 16'h2ee0;
  localparam logic [LEVEL_W-1:0] STEP_MV = 16'h07d0;

  // ****************************************************************
  // Lockout control register layout, bit 7 down to bit 0.
  // ****************************************************************
  typedef struct packed {
    logic low_lock_enable;
    logic low_event_status;
    logic low_rise_edge_select;
    logic low_fall_edge_select;
    logic high_lock_enable;
    logic high_event_status;
    logic high_rise_edge_select;
    logic high_fall_edge_select;
  } lockout_control_t;

  // Edge selection handed to one lockout channel.
  typedef struct packed {
    logic rise_select;
    logic fall_select;
  } edge_select_t;

endpackage
`default_nettype wire

// file: rtl/sync_bits.sv
// Two-stage synchroniser for a vector of asynchronous levels.
`default_nettype none
module sync_bits #(
  parameter int WIDTH = 2
) (
  input wire logic clk_i,
  input wire logic rst_i,
  input wire logic [WIDTH-1:0] async_i,
  output logic [WIDTH-1:0] sync_o
);

  logic [WIDTH-1:0] meta_r;
  logic [WIDTH-1:0] meta_nxt;
  logic [WIDTH-1:0] sync_r;
  logic [WIDTH-1:0] sync_nxt;

  always_comb begin
    meta_nxt = async_i;
    sync_nxt = meta_r;
  end

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      meta_r <= '0;
      sync_r <= '0;
    end else begin
      meta_r <= meta_nxt;
      sync_r <= sync_nxt;
    end
  end

  assign sync_o = sync_r;

endmodule
`default_nettype wire

// file: rtl/lockout_channel.sv
// One lockout channel: condition flag with optional edge capture and status.
`default_nettype none
module lockout_channel
  import lockout_pkg::*;
(
  input wire logic clk_i,
  input wire logic rst_i,
  input wire logic cond_i,
  input wire edge_select_t sel_i,
  output logic flag_o,
  output logic status_o
);

  logic cond_d_r;
  logic cond_d_nxt;
  logic flag_r;
  logic flag_nxt;
  logic status_r;
  logic status_nxt;
  logic edge_hit;

  always_comb begin
    cond_d_nxt = cond_i;
    edge_hit = (sel_i.rise_select & cond_i & ~cond_d_r) | (sel_i.fall_select & ~cond_i & cond_d_r); // RL18
    flag_nxt = cond_i | edge_hit; // RL1 RL2 RL4 RL5 RL7 RL8 RL10
    status_nxt = cond_i; // RL15 RL16
  end

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      cond_d_r <= 1'b0;
      flag_r <= 1'b0;
      status_r <= 1'b0;
    end else begin
      cond_d_r <= cond_d_nxt;
      flag_r <= flag_nxt;
      status_r <= status_nxt;
    end
  end

  assign flag_o = flag_r;
  assign status_o = status_r;

endmodule
`default_nettype wire

// file: rtl/input_supply_lockout_monitor.sv
// Input supply lockout monitor: comparator handling, gate gating, Wishbone registers.
//
// Added by the designer: the Wishbone interface to the registers and the register addresses.
`default_nettype none
//
// Contract
// RL1 - Set low flag while supply below threshold.
// RL2 - Low flag clears itself above threshold.
// RL3 - Low lock enabled: gates off while below.
// RL4 - Low flag sets regardless of lock enable.
// RL5 - Flags ignore interrupt enables entirely.
// RL6 - Low code: 4V plus 2V per step.
// RL7 - Set high flag while supply above threshold.
// RL8 - High flag clears itself below threshold.
// RL9 - High lock enabled: gates off while above.
// RL10 - High flag sets regardless of lock enable.
// RL11 - High code: 12V plus 2V per step.
// RL12 - Software programs both thresholds after power-up.
// RL13 - Software keeps low below high threshold.
// RL14 - Threshold upper bits read zero, unwritable.
// RL15 - Read-only low event status bit.
// RL16 - Read-only high event status bit.
// RL17 - Control register layout, all reset zero.
// RL18 - Edge selects also set flags on transitions.
// RL19 - Comparators pass two-stage synchroniser first.
// RL20 - Gate-off is OR of enabled conditions.
module input_supply_lockout_monitor
  import lockout_pkg::*;
(
  input wire logic clk_i,
  input wire logic rst_i,
  input wire logic wb_cyc_i,
  input wire logic wb_stb_i,
  input wire logic wb_we_i,
  input wire logic [ADR_W-1:0] wb_adr_i,
  input wire logic [3:0] wb_sel_i,
  input wire logic [31:0] wb_dat_i,
  output logic [31:0] wb_dat_o,
  output logic wb_ack_o,
  input wire logic low_cmp_i,
  input wire logic high_cmp_i,
  input wire logic hs_pwm_i,
  input wire logic ls_pwm_i,
  output logic high_side_gate_o,
  output logic low_side_gate_o,
  output logic gate_off_o,
  output logic [CODE_W-1:0] low_threshold_code_o,
  output logic [CODE_W-1:0] high_threshold_code_o,
  output logic [LEVEL_W-1:0] low_level_mv_o,
  output logic [LEVEL_W-1:0] high_level_mv_o,
  output logic vin_low_flag_o,
  output logic vin_high_flag_o
);

  // ****************************************************************
  // Comparator synchronisation.
  // ****************************************************************
  logic [NUM_CH-1:0] cmp_sync;
  logic [NUM_CH-1:0] flag;
  logic [NUM_CH-1:0] status;
  edge_select_t [NUM_CH-1:0] edge_sel;

  sync_bits #(
    .WIDTH(NUM_CH)
  ) u_sync (
    .clk_i(clk_i),
    .rst_i(rst_i),
    .async_i({high_cmp_i, low_cmp_i}), // RL19
    .sync_o(cmp_sync)
  );

  // ****************************************************************
  // Registers.
  // ****************************************************************
  lockout_control_t ctrl_r;
  lockout_control_t ctrl_nxt;
  logic [CODE_W-1:0] low_code_r;
  logic [CODE_W-1:0] low_code_nxt;
  logic [CODE_W-1:0] high_code_r;
  logic [CODE_W-1:0] high_code_nxt;
  logic ack_r;
  logic ack_nxt;
  logic [31:0] dat_r;
  logic [31:0] dat_nxt;
  logic req;
  logic wr;
  lockout_control_t ctrl_view;

  assign edge_sel[LOW_CH] = '{rise_select: ctrl_r.low_rise_edge_select,
                              fall_select: ctrl_r.low_fall_edge_select};
  assign edge_sel[HIGH_CH] = '{rise_select: ctrl_r.high_rise_edge_select,
                               fall_select: ctrl_r.high_fall_edge_select};

  // ****************************************************************
  // Lockout channels, one per comparator.
  // ****************************************************************
  generate
    for (genvar ch = 0; ch < NUM_CH; ch++) begin : g_ch
      lockout_channel u_ch (
        .clk_i(clk_i),
        .rst_i(rst_i),
        .cond_i(cmp_sync[ch]),
        .sel_i(edge_sel[ch]),
        .flag_o(flag[ch]),
        .status_o(status[ch])
      );
    end
  endgenerate

  // ****************************************************************
  // Wishbone slave.
  // ****************************************************************
  always_comb begin
    req = wb_cyc_i & wb_stb_i & ~ack_r;
    wr = req & wb_we_i & wb_sel_i[0];
    ack_nxt = req;
    ctrl_view = ctrl_r;
    ctrl_view.low_event_status = status[LOW_CH]; // RL15
    ctrl_view.high_event_status = status[HIGH_CH]; // RL16
    ctrl_nxt = ctrl_r;
    low_code_nxt = low_code_r;
    high_code_nxt = high_code_r;
    if (wr) begin
      case (wb_adr_i)
        CTRL_OFS: begin
          ctrl_nxt = lockout_control_t'(wb_dat_i[REG_W-1:0] & CTRL_WR_MASK); // RL17
        end
        LOW_THR_OFS: begin
          low_code_nxt = wb_dat_i[CODE_W-1:0]; // RL14
        end
        HIGH_THR_OFS: begin
          high_code_nxt = wb_dat_i[CODE_W-1:0]; // RL14
        end
        default: begin
          ctrl_nxt = ctrl_r;
        end
      endcase
    end
    dat_nxt = '0;
    if (req && !wb_we_i) begin
      case (wb_adr_i)
        CTRL_OFS: begin
          dat_nxt = {24'h000000, ctrl_view}; // RL17
        end
        LOW_THR_OFS: begin
          dat_nxt = {28'h0000000, low_code_r}; // RL14
        end
        HIGH_THR_OFS: begin
          dat_nxt = {28'h0000000, high_code_r}; // RL14
        end
        FLAG_OFS: begin
          dat_nxt = {30'h0000000, flag[HIGH_CH], flag[LOW_CH]}; // RL5
        end
        default: begin
          dat_nxt = '0;
        end
      endcase
    end
  end

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      ctrl_r <= lockout_control_t'(CTRL_RST); // RL17
      low_code_r <= CODE_RST;
      high_code_r <= CODE_RST;
      ack_r <= 1'b0;
      dat_r <= '0;
    end else begin
      ctrl_r <= ctrl_nxt;
      low_code_r <= low_code_nxt;
      high_code_r <= high_code_nxt;
      ack_r <= ack_nxt;
      dat_r <= dat_nxt;
    end
  end

  // ****************************************************************
  // Gate-off path and threshold levels.
  // ****************************************************************
  logic off_r;
  logic off_nxt;
  logic hs_r;
  logic hs_nxt;
  logic ls_r;
  logic ls_nxt;
  logic [LEVEL_W-1:0] low_mv_r;
  logic [LEVEL_W-1:0] low_mv_nxt;
  logic [LEVEL_W-1:0] high_mv_r;
  logic [LEVEL_W-1:0] high_mv_nxt;

  always_comb begin
    off_nxt = (ctrl_r.low_lock_enable & cmp_sync[LOW_CH]) // RL3 RL20
            | (ctrl_r.high_lock_enable & cmp_sync[HIGH_CH]); // RL9 RL20
    hs_nxt = hs_pwm_i & ~off_nxt; // RL3 RL9
    ls_nxt = ls_pwm_i & ~off_nxt; // RL3 RL9
    low_mv_nxt = LOW_BASE_MV + LEVEL_W'(STEP_MV * LEVEL_W'(low_code_r)); // RL6
    high_mv_nxt = HIGH_BASE_MV + LEVEL_W'(STEP_MV * LEVEL_W'(high_code_r)); // RL11
  end

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      off_r <= 1'b0;
      hs_r <= 1'b0;
      ls_r <= 1'b0;
      low_mv_r <= LOW_BASE_MV;
      high_mv_r <= HIGH_BASE_MV;
    end else begin
      off_r <= off_nxt;
      hs_r <= hs_nxt;
      ls_r <= ls_nxt;
      low_mv_r <= low_mv_nxt;
      high_mv_r <= high_mv_nxt;
    end
  end

  assign wb_ack_o = ack_r;
  assign wb_dat_o = dat_r;
  assign gate_off_o = off_r;
  assign high_side_gate_o = hs_r;
  assign low_side_gate_o = ls_r;
  assign low_threshold_code_o = low_code_r;
  assign high_threshold_code_o = high_code_r;
  assign low_level_mv_o = low_mv_r;
  assign high_level_mv_o = high_mv_r;
  assign vin_low_flag_o = flag[LOW_CH];
  assign vin_high_flag_o = flag[HIGH_CH];

endmodule
`default_nettype wire

// file: testbench/vin_comparator_model.sv
// Comparator model that turns the supply level into lockout comparator outputs.
`default_nettype none
module vin_comparator_model
  import lockout_pkg::*;
(
  input wire logic [LEVEL_W-1:0] supply_mv_i,
  input wire logic [LEVEL_W-1:0] low_level_mv_i,
  input wire logic [LEVEL_W-1:0] high_level_mv_i,
  output logic low_cmp_o,
  output logic high_cmp_o
);
  assign low_cmp_o = supply_mv_i < low_level_mv_i;
  assign high_cmp_o = supply_mv_i > high_level_mv_i;
endmodule
`default_nettype wire

// file: testbench/lockout_asserts.sv
// Assertions on the ports of the lockout monitor.
`default_nettype none
module lockout_asserts
  import lockout_pkg::*;
(
  input wire logic clk_i,
  input wire logic rst_i,
  input wire logic low_cmp_i,
  input wire logic high_cmp_i,
  input wire logic hs_pwm_i,
  input wire logic high_side_gate_o,
  input wire logic low_side_gate_o,
  input wire logic gate_off_o,
  input wire logic [CODE_W-1:0] low_threshold_code_o,
  input wire logic [LEVEL_W-1:0] low_level_mv_o,
  input wire logic vin_low_flag_o,
  input wire logic vin_high_flag_o
);
  // ****************************************
  // Port relations.
  // ****************************************
  logic [1:0] warm_r;
  default clocking @(posedge clk_i); endclocking
  default disable iff (rst_i || warm_r != 2'h3);
  // Holds the checks off until the comparator synchroniser has refilled after reset.
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      warm_r <= 2'h0;
    end else if (warm_r != 2'h3) begin
      warm_r <= warm_r + 2'h1;
    end
  end
  sequence s_low_held;
    low_cmp_i [*3];
  endsequence
  sequence s_high_held;
    high_cmp_i [*3];
  endsequence
  a_low_flag_set: assert property (s_low_held |=> vin_low_flag_o)
    else $error("low flag missing");
  a_low_flag_clear: assert property ((!low_cmp_i) [*5] |=> !vin_low_flag_o)
    else $error("low flag stuck");
  a_high_flag_set: assert property (s_high_held |=> vin_high_flag_o)
    else $error("high flag missing");
  a_high_flag_clear: assert property ((!high_cmp_i) [*5] |=> !vin_high_flag_o)
    else $error("high flag stuck");
  a_gate_hold: assert property (gate_off_o |-> !high_side_gate_o && !low_side_gate_o)
    else $error("gates driven in lockout");
  a_gate_cause: assert property (gate_off_o |-> vin_low_flag_o || vin_high_flag_o)
    else $error("gate off without condition");
  a_gate_pass: assert property (!$past(rst_i) |-> high_side_gate_o == ($past(hs_pwm_i) && !gate_off_o))
    else $error("high gate wrong");
  a_sync_delay: assert property ($rose(vin_low_flag_o) |-> $past(low_cmp_i, 3))
    else $error("low flag early");
  a_low_scale: assert property ($stable(low_threshold_code_o) |->
    low_level_mv_o == 16'h0fa0 + 16'h07d0 * low_threshold_code_o)
    else $error("low level wrong");
endmodule
bind input_supply_lockout_monitor lockout_asserts i_chk (.clk_i(clk_i), .rst_i(rst_i),
  .low_cmp_i(low_cmp_i), .high_cmp_i(high_cmp_i), .hs_pwm_i(hs_pwm_i),
  .high_side_gate_o(high_side_gate_o), .low_side_gate_o(low_side_gate_o), .gate_off_o(gate_off_o),
  .low_threshold_code_o(low_threshold_code_o), .low_level_mv_o(low_level_mv_o),
  .vin_low_flag_o(vin_low_flag_o), .vin_high_flag_o(vin_high_flag_o));
`default_nettype wire

// file: testbench/input_supply_lockout_monitor_tb_top.sv
// Self-checking bench for the input supply lockout monitor.
`default_nettype none
module input_supply_lockout_monitor_tb_top
  import lockout_pkg::*;
;
  timeunit 1ns;
  timeprecision 1ns;
  // ****************************************
  // Bench.
  // ****************************************
  typedef struct packed {
    logic [ADR_W-1:0] a;
    logic [31:0] d;
    logic [31:0] e;
  } row_t;
  row_t rows [5] = '{'{LOW_THR_OFS, 32'hf5, 32'h05}, '{HIGH_THR_OFS, 32'hfa, 32'h0a},
    '{CTRL_OFS, 32'hff, 32'hbb}, '{FLAG_OFS, 32'hff, 32'h00}, '{4'h2, 32'hff, 32'h00}};
  logic clk_i, rst_i, cyc, stb, we, ack, hs, ls, low_cmp, high_cmp, hs_g, ls_g, off, lf, hf;
  logic [ADR_W-1:0] adr;
  logic [31:0] wdat, dat, rdat;
  logic [LEVEL_W-1:0] ll, hl, mv;
  logic [CODE_W-1:0] lc, hc;
  int miscompares = 0;
  int total_checks = 0;
  int cyc_n = 0;
  input_supply_lockout_monitor i_dut (.clk_i(clk_i), .rst_i(rst_i), .wb_cyc_i(cyc), .wb_stb_i(stb),
    .wb_we_i(we), .wb_adr_i(adr), .wb_sel_i(4'hf), .wb_dat_i(wdat), .wb_dat_o(dat), .wb_ack_o(ack),
    .low_cmp_i(low_cmp), .high_cmp_i(high_cmp), .hs_pwm_i(hs), .ls_pwm_i(ls), .high_side_gate_o(hs_g),
    .low_side_gate_o(ls_g), .gate_off_o(off), .low_threshold_code_o(lc), .high_threshold_code_o(hc),
    .low_level_mv_o(ll), .high_level_mv_o(hl), .vin_low_flag_o(lf), .vin_high_flag_o(hf));
  vin_comparator_model i_vin (.supply_mv_i(mv), .low_level_mv_i(ll), .high_level_mv_i(hl),
    .low_cmp_o(low_cmp), .high_cmp_o(high_cmp));
  initial begin
    clk_i = 1'b0;
    forever #10 clk_i = ~clk_i;
  end
  always @(posedge clk_i) begin
    cyc_n <= cyc_n + 1;
    if (cyc_n == 3000) begin
      miscompares++;
      print_verdict();
    end
  end
  task automatic chk(input string name, input logic [31:0] exp, input logic [31:0] seen);
    total_checks++;
    if (seen !== exp) begin
      miscompares++;
      $display("[FAIL] %s expected %h seen %h", name, exp, seen);
    end
  endtask
  task automatic bus(input logic w, input logic [ADR_W-1:0] a, input logic [31:0] d);
    cyc <= 1'b1;
    stb <= 1'b1;
    we <= w;
    adr <= a;
    wdat <= d;
    @(posedge clk_i iff ack === 1'b1);
    rdat = dat;
    cyc <= 1'b0;
    stb <= 1'b0;
    @(posedge clk_i);
  endtask
  task automatic ev(input logic [31:0] ctl, input logic [15:0] v, input logic [1:0] fl, input logic g);
    bus(1'b1, CTRL_OFS, ctl);
    mv <= v;
    repeat (5) @(posedge clk_i);
    @(negedge clk_i);
    chk("flags", {30'h0, fl}, {30'h0, hf, lf});
    chk("gate off", {31'h0, g}, {31'h0, off});
    chk("gates", {30'h0, ~g, ~g}, {30'h0, hs_g, ls_g});
    @(posedge clk_i);
    bus(1'b0, FLAG_OFS, 32'h0);
    chk("flag reg", {30'h0, fl}, rdat);
    bus(1'b0, CTRL_OFS, 32'h0);
    chk("ctrl", ctl | {25'h0, fl[0], 3'h0, fl[1], 2'h0}, rdat);
    mv <= 16'h4e20;
    repeat (6) @(posedge clk_i);
    @(negedge clk_i);
    chk("flags off", 32'h3, {30'h0, ~hf, ~lf});
    chk("gates on", 32'h3, {30'h0, hs_g, ls_g});
    @(posedge clk_i);
  endtask
  task automatic print_verdict();
    $display("checks %0d mismatches %0d", total_checks, miscompares);
    if (miscompares == 0 && total_checks > 0) begin
      $display("SIMULATION PASSED");
    end else begin
      $display("SIMULATION FAILED");
    end
    $finish;
  endtask
  initial begin
    rst_i = 1'b1;
    cyc = 1'b0;
    stb = 1'b0;
    we = 1'b0;
    adr = '0;
    wdat = '0;
    hs = 1'b1;
    ls = 1'b1;
    mv = 16'h4e20;
    repeat (3) @(posedge clk_i);
    @(negedge clk_i);
    chk("reset out", 32'h0, {29'h0, off, hs_g, ls_g});
    chk("reset mv", {16'h2ee0, 16'h0fa0}, {hl, ll});
    @(posedge clk_i);
    rst_i <= 1'b0;
    @(posedge clk_i);
    bus(1'b0, CTRL_OFS, 32'h0);
    chk("ctrl reset", 32'h0, rdat);
    for (int i = 0; i < 5; i++) begin
      bus(1'b1, rows[i].a, rows[i].d);
      bus(1'b0, rows[i].a, 32'h0);
      chk("reg", rows[i].e, rdat);
    end
    for (int c = 0; c < 16; c++) begin
      bus(1'b1, LOW_THR_OFS, 32'(c));
      bus(1'b1, HIGH_THR_OFS, 32'(c));
      @(negedge clk_i);
      chk("low mv", 32'h0fa0 + 32'h07d0 * c, {16'h0, ll});
      chk("high mv", 32'h2ee0 + 32'h07d0 * c, {16'h0, hl});
      chk("codes", {24'h0, 4'(c), 4'(c)}, {24'h0, hc, lc});
      @(posedge clk_i);
    end
    bus(1'b1, LOW_THR_OFS, 32'h5);
    bus(1'b1, HIGH_THR_OFS, 32'ha);
    ev(32'h80, 16'h2710, 2'b01, 1'b1);
    ev(32'h00, 16'h2710, 2'b01, 1'b0);
    ev(32'h08, 16'h9c40, 2'b10, 1'b1);
    ev(32'h00, 16'h9c40, 2'b10, 1'b0);
    bus(1'b1, CTRL_OFS, 32'h10);
    mv <= 16'h2710;
    repeat (5) @(posedge clk_i);
    mv <= 16'h4e20;
    repeat (3) @(posedge clk_i);
    @(negedge clk_i);
    chk("fall pulse", 32'h1, {31'h0, lf});
    @(negedge clk_i);
    chk("pulse end", 32'h0, {31'h0, lf});
    @(posedge clk_i);
    hs <= 1'b0;
    @(posedge clk_i);
    @(negedge clk_i);
    chk("pwm pass", 32'h1, {30'h0, hs_g, ls_g});
    @(posedge clk_i);
    hs <= 1'b1;
    rst_i <= 1'b1;
    repeat (2) @(posedge clk_i);
    rst_i <= 1'b0;
    @(posedge clk_i);
    bus(1'b0, CTRL_OFS, 32'h0);
    chk("ctrl rerst", 32'h0, rdat & 32'hbb);
    print_verdict();
  end
endmodule
`default_nettype wire
